// >>> core/sgwr_map.vh
// Array geometry, address pin bits, mode field layout and codes, and timing constants for the write path
`ifndef SGWR_MAP_VH
`define SGWR_MAP_VH

// Array geometry
`define SGWR_DQ_W 32
`define SGWR_ADDR_W 10
`define SGWR_COL_W 8
`define SGWR_LANES 4
`define SGWR_LANE_W 8
`define SGWR_BLK_W 5
`define SGWR_BLK_LSB 3
`define SGWR_BLK_OFS_W 3
`define SGWR_MR_W 10

// Address pins with a fixed meaning
`define SGWR_AP_BIT 9
`define SGWR_PREALL_BIT 9
`define SGWR_SR_COLOR_BIT 6
`define SGWR_SR_MASK_BIT 5

// Mode register layout (bit 9 holds the bank select pin)
`define SGWR_MR_BL_LSB 0
`define SGWR_MR_BL_W 3
`define SGWR_MR_ILV_BIT 3
`define SGWR_MR_CL_LSB 4
`define SGWR_MR_CL_W 3
`define SGWR_MR_TM_LSB 7
`define SGWR_MR_TM_W 2
`define SGWR_MR_SW_BIT 9
`define SGWR_MR_RST 10'h000

// Burst length codes
`define SGWR_BL_1 3'h0
`define SGWR_BL_2 3'h1
`define SGWR_BL_4 3'h2
`define SGWR_BL_8 3'h3
`define SGWR_BL_FULL 3'h7

// Last beat index per burst length
`define SGWR_LAST_1 8'h00
`define SGWR_LAST_2 8'h01
`define SGWR_LAST_4 8'h03
`define SGWR_LAST_8 8'h07

// Column latency codes
`define SGWR_CL_1 3'h1
`define SGWR_CL_2 3'h2
`define SGWR_CL_3 3'h3

// Timing in ns and the clock period
`define SGWR_CLK_NS 10
`define SGWR_WR_NS 15
`define SGWR_BPL_NS 20
`define SGWR_TMR_W 4

`endif

// >>> core/sgwr_mode_reg.v
// Operating mode register with field decode
`timescale 1ns/1ps
`default_nettype none
`include "sgwr_map.vh"

module sgwr_mode_reg (
    input wire i_sys_clk,                         // System clock
    input wire i_rstn,                            // Sync reset, active low
    input wire i_load,                            // Mode register set taken
    input wire [`SGWR_MR_W-1:0] i_data,           // Bank select and A8..A0
    output wire [`SGWR_MR_W-1:0] o_mode,          // Raw register contents
    output reg [`SGWR_COL_W-1:0] o_last_idx,      // Last beat index
    output wire o_full_page,                      // Full page bursts
    output wire o_interleave,                     // Interleaved order
    output reg [1:0] o_latency,                   // Column latency in clocks
    output wire o_single_write,                   // Burst read single write
    output wire o_bl_reserved,                    // Burst length code reserved
    output wire o_cl_reserved,                    // Latency code reserved
    output wire o_test_mode                       // Test bits not zero
);
    reg [`SGWR_MR_W-1:0] mode_ff;
    wire [`SGWR_MR_BL_W-1:0] bl_code;
    wire [`SGWR_MR_CL_W-1:0] cl_code;

    always @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            mode_ff <= `SGWR_MR_RST;
        end else if (i_load) begin
            mode_ff <= i_data;
        end
    end

    assign o_mode = mode_ff;
    assign bl_code = mode_ff[`SGWR_MR_BL_LSB +: `SGWR_MR_BL_W];
    assign cl_code = mode_ff[`SGWR_MR_CL_LSB +: `SGWR_MR_CL_W];
    assign o_interleave = mode_ff[`SGWR_MR_ILV_BIT];
    assign o_single_write = mode_ff[`SGWR_MR_SW_BIT];
    assign o_full_page = (bl_code == `SGWR_BL_FULL);
    assign o_test_mode = |mode_ff[`SGWR_MR_TM_LSB +: `SGWR_MR_TM_W];

    always @* begin
        case (bl_code)
            `SGWR_BL_1: o_last_idx = `SGWR_LAST_1;
            `SGWR_BL_2: o_last_idx = `SGWR_LAST_2;
            `SGWR_BL_4: o_last_idx = `SGWR_LAST_4;
            `SGWR_BL_8: o_last_idx = `SGWR_LAST_8;
            default: o_last_idx = `SGWR_LAST_1;
        endcase
    end
    assign o_bl_reserved = (bl_code > `SGWR_BL_8) &&
        (bl_code != `SGWR_BL_FULL);

    always @* begin
        case (cl_code)
            `SGWR_CL_1: o_latency = 2'h1;
            `SGWR_CL_2: o_latency = 2'h2;
            `SGWR_CL_3: o_latency = 2'h3;
            default: o_latency = 2'h0;
        endcase
    end
    assign o_cl_reserved = (o_latency == 2'h0);
endmodule
`default_nettype wire

// >>> core/sgwr_col_gen.v
// Burst column address generator, sequential or interleaved
`timescale 1ns/1ps
`default_nettype none
`include "sgwr_map.vh"

module sgwr_col_gen (
    input wire [`SGWR_COL_W-1:0] i_start,         // Start column
    input wire [`SGWR_COL_W-1:0] i_idx,           // Beat index
    input wire i_interleave,                      // Interleaved order
    output reg [`SGWR_COL_W-1:0] o_col            // Column of this beat
);
    always @* begin
        if (i_interleave) begin
            o_col = {i_start[`SGWR_COL_W-1:`SGWR_BLK_LSB],
                i_start[`SGWR_BLK_LSB-1:0] ^ i_idx[`SGWR_BLK_LSB-1:0]};
        end else begin
            o_col = i_start + i_idx;
        end
    end
endmodule
`default_nettype wire

// >>> core/sgwr_core.v
// Write path of a two-bank graphics DRAM: bursts, block writes, mode register
`timescale 1ns/1ps
`default_nettype none
`include "sgwr_map.vh"

module sgwr_core #(
    parameter WR_NS = `SGWR_WR_NS,                // Write recovery time
    parameter BPL_NS = `SGWR_BPL_NS               // Block write to precharge
) (
    input wire i_sys_clk,                         // System clock
    input wire i_rstn,                            // Sync reset, active low
    input wire i_cs_n,                            // Chip select, active low
    input wire i_ras_n,                           // Row strobe, active low
    input wire i_cas_n,                           // Column strobe, active low
    input wire i_we_n,                            // Write strobe, active low
    input wire i_special_function_select,         // Special function input
    input wire i_bank_select,                     // Bank select
    input wire [`SGWR_ADDR_W-1:0] i_addr,         // Address pins
    input wire [`SGWR_LANES-1:0] i_dqm,           // Byte masks, high masks
    input wire [`SGWR_DQ_W-1:0] i_dq,             // Write data lines
    output reg o_wr_en,                           // Array word write pulse
    output reg o_wr_bank,                         // Bank of the write
    output reg [`SGWR_COL_W-1:0] o_wr_col,        // Column of word write
    output reg [`SGWR_DQ_W-1:0] o_wr_data,        // Data or colour value
    output reg [`SGWR_DQ_W-1:0] o_wr_bit_en,      // Per-bit write enables
    output reg o_blk_wr,                          // Block write pulse
    output reg [`SGWR_BLK_W-1:0] o_blk_addr,      // Block of eight columns
    output reg [`SGWR_DQ_W-1:0] o_blk_col_en,     // Column by lane enables
    output reg o_bank_close,                      // Auto precharge pulse
    output reg o_close_bank,                      // Bank of auto precharge
    output wire o_burst_active,                   // Write burst in progress
    output wire [`SGWR_MR_W-1:0] o_mode,          // Mode register contents
    output wire [1:0] o_latency,                  // Decoded column latency
    output wire o_mode_reserved                   // Reserved or test code set
);
    // Recovery counts round up to whole clocks
    localparam integer WR_RAW = (WR_NS + `SGWR_CLK_NS - 1) / `SGWR_CLK_NS;
    localparam integer BPL_RAW = (BPL_NS + `SGWR_CLK_NS - 1) / `SGWR_CLK_NS;
    // Counts beyond the timer width are not supported
    localparam [`SGWR_TMR_W-1:0] WR_CYC = WR_RAW[`SGWR_TMR_W-1:0];
    localparam [`SGWR_TMR_W-1:0] BPL_CYC = BPL_RAW[`SGWR_TMR_W-1:0];

    // Command decode, all pins are on this clock
    wire sel = ~i_cs_n;
    wire special_function_select = i_special_function_select;
    wire is_act = sel & ~i_ras_n & i_cas_n & i_we_n;
    wire is_pre = sel & ~i_ras_n & i_cas_n & ~i_we_n;
    wire is_rd = sel & i_ras_n & ~i_cas_n & i_we_n & ~special_function_select;
    wire is_wr = sel & i_ras_n & ~i_cas_n & ~i_we_n & ~special_function_select;
    wire is_bw = sel & i_ras_n & ~i_cas_n & ~i_we_n & special_function_select;
    wire is_mrs = sel & ~i_ras_n & ~i_cas_n & ~i_we_n & ~special_function_select;
    wire is_smrs = sel & ~i_ras_n & ~i_cas_n & ~i_we_n & special_function_select;
    wire is_bst = sel & i_ras_n & i_cas_n & ~i_we_n & ~special_function_select;

    // Mode register
    wire [`SGWR_COL_W-1:0] mr_last;
    wire mr_full;
    wire mr_ilv;
    wire mr_single;
    wire mr_bl_res;
    wire mr_cl_res;
    wire mr_test;

    sgwr_mode_reg u_mode (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .i_load(is_mrs),
        .i_data({i_bank_select, i_addr[`SGWR_MR_W-2:0]}),
        .o_mode(o_mode),
        .o_last_idx(mr_last),
        .o_full_page(mr_full),
        .o_interleave(mr_ilv),
        .o_latency(o_latency),
        .o_single_write(mr_single),
        .o_bl_reserved(mr_bl_res),
        .o_cl_reserved(mr_cl_res),
        .o_test_mode(mr_test)
    );
    assign o_mode_reserved = mr_bl_res | mr_cl_res | mr_test;

    // Colour, bit mask and per-bank masked-row flags
    reg [`SGWR_DQ_W-1:0] color_ff;
    reg [`SGWR_DQ_W-1:0] mask_ff;
    reg [1:0] mwe_ff;

    always @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            color_ff <= 32'h00000000;
            mask_ff <= 32'hffffffff;
            mwe_ff <= 2'h0;
        end else begin
            if (is_smrs && i_addr[`SGWR_SR_COLOR_BIT] &&
                    !i_addr[`SGWR_SR_MASK_BIT]) begin
                color_ff <= i_dq;
            end
            if (is_smrs && i_addr[`SGWR_SR_MASK_BIT] &&
                    !i_addr[`SGWR_SR_COLOR_BIT]) begin
                mask_ff <= i_dq;
            end
            if (is_act) begin
                mwe_ff[i_bank_select] <= special_function_select;
            end
        end
    end

    // Write burst state
    reg wb_act_ff;
    reg wb_bank_ff;
    reg [`SGWR_COL_W-1:0] wb_start_ff;
    reg [`SGWR_COL_W-1:0] wb_idx_ff;
    reg [`SGWR_COL_W-1:0] wb_last_ff;
    reg wb_full_ff;
    reg wb_ilv_ff;
    reg wb_ap_ff;
    assign o_burst_active = wb_act_ff;

    // Single word in single write mode
    wire [`SGWR_COL_W-1:0] cmd_last = mr_single ? `SGWR_LAST_1 : mr_last;
    wire cmd_full = mr_full & ~mr_single;
    // Read, precharge, burst stop, block write and mode register set commands end the burst; activate does not
    wire wb_stop = is_rd | is_pre | is_bst | is_bw | is_mrs | is_smrs;
    wire wb_beat = wb_act_ff & ~wb_stop & ~is_wr;
    wire beat = is_wr | wb_beat;
    wire beat_bank = is_wr ? i_bank_select : wb_bank_ff;
    wire beat_last = is_wr ? (cmd_last == `SGWR_LAST_1) && !cmd_full :
        (wb_idx_ff == wb_last_ff) && !wb_full_ff;
    wire beat_ap = is_wr ? i_addr[`SGWR_AP_BIT] : wb_ap_ff;

    wire [`SGWR_COL_W-1:0] cg_start = is_wr ? i_addr[`SGWR_COL_W-1:0] :
        wb_start_ff;
    wire [`SGWR_COL_W-1:0] cg_idx = is_wr ? 8'h00 : wb_idx_ff;
    wire cg_ilv = is_wr ? mr_ilv : wb_ilv_ff;
    wire [`SGWR_COL_W-1:0] beat_col;

    sgwr_col_gen u_col (
        .i_start(cg_start),
        .i_idx(cg_idx),
        .i_interleave(cg_ilv),
        .o_col(beat_col)
    );

    always @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            wb_act_ff <= 1'b0;
            wb_bank_ff <= 1'b0;
            wb_start_ff <= 8'h00;
            wb_idx_ff <= 8'h00;
            wb_last_ff <= 8'h00;
            wb_full_ff <= 1'b0;
            wb_ilv_ff <= 1'b0;
            wb_ap_ff <= 1'b0;
        end else if (is_wr) begin
            // First beat is taken with the command itself
            wb_act_ff <= ~beat_last;
            wb_bank_ff <= i_bank_select;
            wb_start_ff <= i_addr[`SGWR_COL_W-1:0];
            wb_idx_ff <= 8'h01;
            wb_last_ff <= cmd_last;
            wb_full_ff <= cmd_full;
            wb_ilv_ff <= mr_ilv;
            wb_ap_ff <= i_addr[`SGWR_AP_BIT];
        end else if (wb_stop) begin
            wb_act_ff <= 1'b0;
        end else if (wb_act_ff) begin
            wb_act_ff <= ~beat_last;
            // Full page wraps through the 8-bit index until a stopping command
            wb_idx_ff <= wb_idx_ff + 8'h01;
        end
    end

    // Byte masks expanded per bit, then gated by the bit mask on masked rows
    wire [`SGWR_DQ_W-1:0] byte_en;
    genvar gb;
    generate
        for (gb = 0; gb < `SGWR_LANES; gb = gb + 1) begin : g_lane
            assign byte_en[gb*`SGWR_LANE_W +: `SGWR_LANE_W] =
                {`SGWR_LANE_W{~i_dqm[gb]}};
        end
    endgenerate
    wire bit_bank = is_bw ? i_bank_select : beat_bank;
    // Mask register only on masked rows
    wire [`SGWR_DQ_W-1:0] bit_en = byte_en &
        (mwe_ff[bit_bank] ? mask_ff : 32'hffffffff);

    // Word and block write outputs toward the array
    always @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            o_wr_en <= 1'b0;
            o_wr_bank <= 1'b0;
            o_wr_col <= 8'h00;
            o_wr_data <= 32'h00000000;
            o_wr_bit_en <= 32'h00000000;
            o_blk_wr <= 1'b0;
            o_blk_addr <= 5'h00;
            o_blk_col_en <= 32'h00000000;
        end else begin
            o_wr_en <= beat;
            o_blk_wr <= is_bw;
            if (beat) begin
                o_wr_bank <= beat_bank;
                o_wr_col <= beat_col;
                o_wr_data <= i_dq;
                o_wr_bit_en <= bit_en;
            end else if (is_bw) begin
                o_wr_bank <= i_bank_select;
                o_wr_data <= color_ff;
                o_wr_bit_en <= bit_en;
                o_blk_addr <= i_addr[`SGWR_COL_W-1:`SGWR_BLK_LSB];
                // Line 8b+k enables column k, lane b
                o_blk_col_en <= i_dq;
            end
        end
    end

    // Auto precharge timer; one pending close at a time, later one wins
    reg [`SGWR_TMR_W-1:0] ap_cnt_ff;
    reg ap_pend_ff;
    reg ap_bank_ff;
    // Fixed bursts with A9 close the bank
    wire ap_wr_start = beat & beat_last & beat_ap;
    // Block write with A9 closes after block time
    wire ap_bw_start = is_bw & i_addr[`SGWR_AP_BIT];

    always @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            ap_cnt_ff <= 4'h0;
            ap_pend_ff <= 1'b0;
            ap_bank_ff <= 1'b0;
            o_bank_close <= 1'b0;
            o_close_bank <= 1'b0;
        end else begin
            o_bank_close <= 1'b0;
            if (ap_bw_start) begin
                ap_pend_ff <= 1'b1;
                ap_cnt_ff <= BPL_CYC;
                ap_bank_ff <= i_bank_select;
            end else if (ap_wr_start) begin
                ap_pend_ff <= 1'b1;
                ap_cnt_ff <= WR_CYC;
                ap_bank_ff <= beat_bank;
            end else if (ap_pend_ff) begin
                if (ap_cnt_ff <= 4'h1) begin
                    ap_pend_ff <= 1'b0;
                    o_bank_close <= 1'b1;
                    o_close_bank <= ap_bank_ff;
                end else begin
                    ap_cnt_ff <= ap_cnt_ff - 4'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> bench/sgwr_core_properties.sv
// Port-level checks on the write path and mode register
`timescale 1ns/1ps
`default_nettype none
module sgwr_core_properties #(
    parameter WR_NS = 15,
    parameter BPL_NS = 20
) (
    input wire i_sys_clk, // Clock
    input wire i_rstn, // Reset
    input wire i_cs_n, // Select
    input wire i_ras_n, // Row strobe
    input wire i_cas_n, // Col strobe
    input wire i_we_n, // Write strobe
    input wire i_special_function_select, // Special
    input wire i_bank_select, // Bank
    input wire [9:0] i_addr, // Address
    input wire [3:0] i_dqm, // Byte masks
    input wire [31:0] i_dq, // Data
    input wire o_wr_en, // Word write
    input wire [7:0] o_wr_col, // Column
    input wire [31:0] o_wr_bit_en, // Bit enables
    input wire o_blk_wr, // Block write
    input wire [4:0] o_blk_addr, // Block
    input wire [31:0] o_blk_col_en, // Col enables
    input wire o_bank_close, // Auto close
    input wire o_burst_active, // Burst on
    input wire [9:0] o_mode, // Mode
    input wire [1:0] o_latency, // Latency
    input wire o_mode_reserved // Reserved
);
    // Walk and strict reading differ by one edge, so allow both
    localparam int WR_LO = (WR_NS + 9) / 10;
    localparam int WR_HI = WR_LO + 1;
    localparam int BPL_LO = (BPL_NS + 9) / 10;
    localparam int BPL_HI = BPL_LO + 1;
    wire sel = !i_cs_n;
    wire [3:0] cmd = {i_ras_n, i_cas_n, i_we_n, i_special_function_select};
    wire wr_c = sel && cmd == 4'h8;
    wire bw_c = sel && cmd == 4'h9;
    wire rd_c = sel && cmd == 4'ha;
    wire ms_c = sel && cmd == 4'h0;
    wire quiet = !sel || cmd[3:1] == 3'h7;
    wire [2:0] bl = o_mode[2:0];
    wire [2:0] cl = o_mode[6:4];
    wire [31:0] dqm_x = {{8{i_dqm[3]}}, {8{i_dqm[2]}}, {8{i_dqm[1]}},
        {8{i_dqm[0]}}};
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);
    property p_wr_start;
        wr_c |=> o_wr_en && o_wr_col == $past(i_addr[7:0]);
    endproperty
    a_wr_start: assert property (p_wr_start)
        else $error("write start column wrong");
    property p_seq;
        o_burst_active && quiet && !o_mode[3]
            |=> o_wr_en && o_wr_col == $past(o_wr_col) + 8'h01;
    endproperty
    a_seq: assert property (p_seq)
        else $error("sequential beat column wrong");
    property p_ilv;
        o_burst_active && quiet && o_mode[3]
            |=> o_wr_en && o_wr_col[7:3] == $past(o_wr_col[7:3]);
    endproperty
    a_ilv: assert property (p_ilv)
        else $error("interleaved beat left its block");
    property p_rd;
        rd_c |=> !o_wr_en && !o_burst_active;
    endproperty
    a_rd: assert property (p_rd)
        else $error("write went on after a read");
    property p_single;
        wr_c && o_mode[9] |=> !o_burst_active;
    endproperty
    a_single: assert property (p_single)
        else $error("single write mode kept bursting");
    property p_blk;
        bw_c |=> o_blk_wr && !o_wr_en && o_blk_addr == $past(i_addr[7:3])
            && o_blk_col_en == $past(i_dq);
    endproperty
    a_blk: assert property (p_blk)
        else $error("block write fields wrong");
    property p_blk_mask;
        bw_c |=> (o_wr_bit_en & $past(dqm_x)) == 32'h0;
    endproperty
    a_blk_mask: assert property (p_blk_mask)
        else $error("masked byte enabled in block write");
    property p_blk_ap;
        bw_c && i_addr[9] |-> ##[BPL_LO:BPL_HI] o_bank_close;
    endproperty
    a_blk_ap: assert property (p_blk_ap)
        else $error("block write auto close missing");
    property p_wr_ap;
        wr_c && i_addr[9] && (bl == 3'h0 || o_mode[9])
            |-> ##[WR_LO:WR_HI] o_bank_close;
    endproperty
    a_wr_ap: assert property (p_wr_ap)
        else $error("write auto close missing");
    property p_mset;
        ms_c |=> o_mode == $past({i_bank_select, i_addr[8:0]});
    endproperty
    a_mset: assert property (p_mset)
        else $error("mode register load wrong");
    property p_res;
        o_mode_reserved == ((bl[2] && bl != 3'h7) || cl == 3'h0 || cl[2]
            || o_mode[8:7] != 2'h0);
    endproperty
    a_res: assert property (p_res)
        else $error("reserved flag wrong");
    property p_lat;
        o_latency == ((cl == 3'h0 || cl[2]) ? 2'h0 : cl[1:0]);
    endproperty
    a_lat: assert property (p_lat)
        else $error("latency decode wrong");
    c_blk_ap: cover property (bw_c && i_addr[9]);
    c_rd: cover property (rd_c && o_burst_active);
    c_single: cover property (wr_c && o_mode[9]);
endmodule
bind sgwr_core sgwr_core_properties #(.WR_NS(WR_NS), .BPL_NS(BPL_NS))
    u_props (.*);
`default_nettype wire

// >>> bench/sgwr_ctrl_model.sv
// Controller model driving command, mask and data pins
`timescale 1ns/1ps
`default_nettype none
module sgwr_ctrl_model (
    input wire logic i_sys_clk, // Clock
    output logic o_cs_n, // Select, active low
    output logic [3:0] o_cmd, // Row, col, write, special
    output logic o_bs, // Bank
    output logic [9:0] o_addr, // Address
    output logic [3:0] o_dqm, // Byte masks
    output logic [31:0] o_dq // Data
);
    initial begin
        o_cs_n = 1'b1;
        o_cmd = 4'hf;
        o_bs = 1'b0;
        o_addr = 10'h000;
        o_dqm = 4'hf;
        o_dq = 32'h0;
    end
    task automatic issue(input logic [3:0] c, input logic b,
            input logic [9:0] a, input logic [3:0] m, input logic [31:0] d);
        @(negedge i_sys_clk);
        o_cs_n = 1'b0;
        o_cmd = c;
        o_bs = b;
        o_addr = a;
        o_dqm = m;
        o_dq = d;
    endtask
    task automatic beat(input logic [3:0] m, input logic [31:0] d);
        @(negedge i_sys_clk);
        o_cs_n = 1'b1;
        o_dqm = m;
        o_dq = d;
    endtask
    task automatic idle();
        @(negedge i_sys_clk);
        o_cs_n = 1'b1;
        o_dqm = 4'hf;
        o_dq = ~o_dq;
        o_addr = ~o_addr;
    endtask
endmodule
`default_nettype wire

// >>> bench/sgwr_core_tb_top.sv
// Self-checking bench for the graphics DRAM write path
`timescale 1ns/1ps
`default_nettype none
module sgwr_core_tb_top;
    localparam int WR_C = 2;
    localparam int BPL_C = 2;
    localparam logic [3:0] C_WR = 4'h8;
    localparam logic [3:0] C_BW = 4'h9;
    localparam logic [3:0] C_RD = 4'ha;
    localparam logic [3:0] C_MS = 4'h0;
    localparam logic [3:0] C_SL = 4'h1;
    localparam logic [3:0] C_STOP = 4'hc;
    logic i_sys_clk = 1'b0;
    logic i_rstn = 1'b0;
    wire cs_n, bs, we, bw, bcl, cb, res, wbk;
    wire [3:0] cmd, dqm;
    wire [9:0] addr, mode;
    wire [31:0] dq, wd, be, bce;
    wire [7:0] col;
    wire [4:0] ba;
    wire [1:0] lat;
    int n_mismatch = 0;
    int checks = 0;
    int cyc = 0;
    int t_close = -1;
    logic cb_q;
    logic [31:0] rs = 32'h56;
    logic [31:0] colv, mskv;
    logic [127:0] q_wr[$];
    logic [127:0] q_blk[$];
    sgwr_ctrl_model ctl (.i_sys_clk(i_sys_clk), .o_cs_n(cs_n), .o_cmd(cmd),
        .o_bs(bs), .o_addr(addr), .o_dqm(dqm), .o_dq(dq));
    sgwr_core #(.WR_NS(15), .BPL_NS(20)) DUT (
        .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_cs_n(cs_n),
        .i_ras_n(cmd[3]), .i_cas_n(cmd[2]), .i_we_n(cmd[1]),
        .i_special_function_select(cmd[0]), .i_bank_select(bs),
        .i_addr(addr), .i_dqm(dqm), .i_dq(dq), .o_wr_en(we),
        .o_wr_bank(wbk), .o_wr_col(col), .o_wr_data(wd), .o_wr_bit_en(be),
        .o_blk_wr(bw), .o_blk_addr(ba), .o_blk_col_en(bce),
        .o_bank_close(bcl), .o_close_bank(cb), .o_burst_active(),
        .o_mode(mode), .o_latency(lat), .o_mode_reserved(res));
    initial begin
        forever #5 i_sys_clk = ~i_sys_clk;
    end
    always @(posedge i_sys_clk) cyc <= cyc + 1;
    // Outputs are read at the falling edge, well away from updates
    always @(negedge i_sys_clk) begin
        if (we === 1'b1) q_wr.push_back({col, wd, be});
        if (bw === 1'b1) q_blk.push_back({wbk, ba, bce, wd, be});
        if (bcl === 1'b1) begin
            t_close = cyc;
            cb_q = cb;
        end
        if (cyc > 5000) begin
            n_mismatch++;
            $display("ERROR %0t run did not finish", $time);
            close_out();
        end
    end
    function automatic logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction
    function automatic logic [31:0] xm(input logic [3:0] m);
        return {{8{~m[3]}}, {8{~m[2]}}, {8{~m[1]}}, {8{~m[0]}}};
    endfunction
    function automatic logic exp_res(input logic [9:0] a);
        return (a[2] && a[2:0] != 3'h7) || a[6:4] == 3'h0 || a[6]
            || a[8:7] != 2'h0;
    endfunction
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_win(input int got, input int lo);
        checks++;
        if (got < lo || got > lo + 1) begin
            n_mismatch++;
            $display("ERROR %0t delay %0d not near %0d", $time, got, lo);
        end
    endtask
    task automatic burst(input logic [2:0] blc, input logic ilv,
            input logic sw, input logic [7:0] s, input int k);
        int nb;
        logic [3:0] m[8];
        logic [31:0] d[8];
        nb = sw ? 1 : (1 << blc);
        nb = (k < nb) ? k : nb;
        ctl.issue(C_MS, sw, {3'h0, 3'h2, ilv, blc}, 4'hf, 32'h0);
        ctl.issue(4'h6, 1'b0, 10'h000, 4'hf, 32'h0);
        for (int i = 0; i < 8; i++) begin
            d[i] = rnd();
            m[i] = d[i][7:4];
        end
        ctl.issue(C_WR, 1'b0, {2'h0, s}, m[0], d[0]);
        for (int i = 1; i < k; i++) ctl.beat(m[i], d[i]);
        if (k < 8) ctl.issue(C_RD, 1'b0, 10'h000, 4'hf, 32'h0);
        repeat (3) ctl.idle();
        chk(128'(q_wr.size()), 128'(nb));
        for (int i = 0; i < nb; i++) begin
            chk(q_wr.pop_front(), {ilv ? {s[7:3], s[2:0] ^ 3'(i)}
                : s + 8'(i), d[i], xm(m[i])});
        end
        q_wr.delete();
    endtask
    task automatic blk(input logic b, input logic ap, input logic [31:0] mk);
        logic [31:0] r;
        logic [31:0] e;
        int t0;
        r = rnd();
        e = rnd();
        t_close = -1;
        ctl.issue(C_BW, b, {ap, 1'b0, r[7:3], 3'h0}, r[11:8], e);
        t0 = cyc;
        repeat (4) ctl.idle();
        chk(q_blk.pop_front(), {b, r[7:3], e, colv, xm(r[11:8]) & mk});
        if (ap) chk_win(t_close - t0, BPL_C);
        if (ap) chk(cb_q, b);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        logic [9:0] a;
        logic [31:0] r;
        int t0;
        repeat (8) @(negedge i_sys_clk);
        i_rstn = 1'b1;
        chk({mode, res}, {10'h000, 1'b1});
        for (int i = 0; i < 9; i++) begin
            a = (i == 8) ? 10'h0a1 : {~i[0], 2'h0, i[2:0], 1'b0, i[2:0]};
            ctl.issue(C_MS, i[0], a, 4'hf, 32'h0);
            ctl.idle();
            chk({mode, lat, res}, {i[0], a[8:0],
                (a[6:4] == 3'h0 || a[6]) ? 2'h0 : a[5:4],
                exp_res(a)});
        end
        $display("test mode codes done");
        burst(3'h2, 1'b0, 1'b0, 8'hfe, 8);
        burst(3'h3, 1'b1, 1'b0, 8'h15, 8);
        burst(3'h3, 1'b0, 1'b0, 8'h40, 3);
        burst(3'h3, 1'b0, 1'b1, 8'h22, 8);
        burst(3'h7, 1'b0, 1'b0, 8'hfd, 6);
        for (int t = 0; t < 12; t++) begin
            r = rnd();
            burst({1'b0, r[1:0]}, r[1] & r[2], r[3], r[15:8],
                int'(r[18:16]) + 1);
        end
        $display("test bursts done");
        colv = rnd();
        mskv = rnd();
        ctl.issue(C_SL, 1'b0, 10'h040, 4'h0, colv);
        ctl.issue(C_SL, 1'b0, 10'h020, 4'h0, mskv);
        ctl.issue(4'h7, 1'b1, 10'h000, 4'hf, 32'h0);
        ctl.issue(4'h6, 1'b0, 10'h000, 4'hf, 32'h0);
        for (int t = 0; t < 6; t++) blk(t[0], t[1], t[0] ? mskv : '1);
        $display("test block writes done");
        ctl.issue(C_MS, 1'b0, 10'h020, 4'hf, 32'h0);
        t_close = -1;
        ctl.issue(C_WR, 1'b1, 10'h233, 4'h0, 32'h0);
        t0 = cyc;
        repeat (6) ctl.idle();
        chk_win(t_close - t0, WR_C);
        chk(cb_q, 1'b1);
        ctl.issue(C_MS, 1'b0, 10'h027, 4'hf, 32'h0);
        t_close = -1;
        ctl.issue(C_WR, 1'b0, 10'h210, 4'h0, 32'h0);
        repeat (3) ctl.beat(4'h0, rnd());
        ctl.issue(C_STOP, 1'b0, 10'h000, 4'hf, 32'h0);
        repeat (8) ctl.idle();
        chk_win(t_close, -1);
        $display("test auto close done");
        close_out();
    end
endmodule
`default_nettype wire
